// [shared/pcpm_pkg.sv]
// constants for the power-management capability register bank
package pcpm_pkg;

  // ************************************************************
  // register offsets (byte address of each dword)
  // ************************************************************
  localparam logic [7:0] PCPM_OFS_PM_CAP   = 8'h80; // id, next pointer, capabilities
  localparam logic [7:0] PCPM_OFS_PM_CTRL  = 8'h84; // control/status, extensions, data
  localparam logic [7:0] PCPM_OFS_MSI_CAP  = 8'h8C; // msi id, downstream only

  // ************************************************************
  // fixed identifiers and pointers
  // ************************************************************
  localparam logic [7:0] PCPM_PM_CAP_ID    = 8'h01; // power-management capability id
  localparam logic [7:0] PCPM_MSI_CAP_ID   = 8'h05; // msi capability id
  localparam logic [7:0] PCPM_NEXT_UP      = 8'h9C; // upstream: vpd capability
  localparam logic [7:0] PCPM_NEXT_DN      = 8'h8C; // downstream: msi capability
  localparam logic [2:0] PCPM_PM_REVISION  = 3'h3;  // revision 1.2 code

  // ************************************************************
  // field positions in the 80h dword
  // ************************************************************
  localparam int PCPM_POS_NEXT    = 8;
  localparam int PCPM_POS_REV     = 16;
  localparam int PCPM_POS_DSI     = 21;
  localparam int PCPM_POS_AUX     = 22;
  localparam int PCPM_POS_D1      = 25;
  localparam int PCPM_POS_D2      = 26;
  localparam int PCPM_POS_PMESUP  = 27;

  // ************************************************************
  // field positions in the 84h dword
  // ************************************************************
  localparam int PCPM_POS_PSTATE  = 0;
  localparam int PCPM_POS_NSR     = 3;
  localparam int PCPM_POS_PMEEN   = 8;
  localparam int PCPM_POS_DSEL    = 9;
  localparam int PCPM_POS_DATA    = 24;

  // ************************************************************
  // reset values of preloadable and writable fields
  // ************************************************************
  localparam logic       PCPM_RST_DSI     = 1'b0;
  localparam logic [2:0] PCPM_RST_AUX     = 3'h7;
  localparam logic       PCPM_RST_D1      = 1'b1;
  localparam logic       PCPM_RST_D2      = 1'b1;
  localparam logic [4:0] PCPM_RST_PMESUP  = 5'h1F;
  localparam logic       PCPM_RST_NSR     = 1'b1;
  localparam logic [7:0] PCPM_RST_DATA    = 8'h00;
  localparam logic [3:0] PCPM_RST_DSEL    = 4'h0;
  localparam logic       PCPM_RST_PMEEN   = 1'b0;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int PCPM_CLK_NS        = 4;  // core clock period
  localparam int PCPM_HOT_RESET_NS  = 16; // least internal reset pulse
  localparam int PCPM_HOT_RESET_CYC =
    (PCPM_HOT_RESET_NS + PCPM_CLK_NS - 1) / PCPM_CLK_NS;

  // ************************************************************
  // device power states
  // ************************************************************
  typedef enum logic [1:0] {
    PCPM_D0    = 2'b00,
    PCPM_D1    = 2'b01,
    PCPM_D2    = 2'b10,
    PCPM_D3HOT = 2'b11
  } pcpm_pstate_t;

  // hot reset sequencer states
  typedef enum logic [1:0] {
    PCPM_HR_IDLE  = 2'b00,
    PCPM_HR_PULSE = 2'b01
  } pcpm_hr_state_t;

endpackage

// [shared/pcpm_cap_if.sv]
// preloadable capability defaults passed from the loader store to the top
`timescale 1ns/1ns
interface pcpm_cap_if;
  logic       dsi;     // device-specific initialization
  logic [2:0] aux;     // auxiliary current code
  logic       d1;      // d1 supported
  logic       d2;      // d2 supported
  logic [4:0] pmesup;  // pme support per state
  logic       nsr;     // no soft reset
  logic [7:0] data;    // pm data byte

  modport store (output dsi, aux, d1, d2, pmesup, nsr, data);
  modport user  (input  dsi, aux, d1, d2, pmesup, nsr, data);
endinterface

// [rtl/pcpm_preload.sv]
// holds the read-only capability defaults that the loader may override
`timescale 1ns/1ns
module pcpm_preload
  import pcpm_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_pre_wr,    // loader write strobe
  input  wire logic [7:0]  i_pre_addr,  // loader dword byte address
  input  wire logic [31:0] i_pre_wdata, // loader data
  pcpm_cap_if.store        cap
);

  // ************************************************************
  // defaults store
  // ************************************************************
  logic       dsi_q, dsi_d;
  logic [2:0] aux_q, aux_d;
  logic       d1_q, d1_d;
  logic       d2_q, d2_d;
  logic [4:0] pmesup_q, pmesup_d;
  logic       nsr_q, nsr_d;
  logic [7:0] data_q, data_d;

  // only the loader path reaches these; config writes never do
  always_comb begin
    dsi_d    = dsi_q;
    aux_d    = aux_q;
    d1_d     = d1_q;
    d2_d     = d2_q;
    pmesup_d = pmesup_q;
    nsr_d    = nsr_q;
    data_d   = data_q;
    if (i_pre_wr && i_pre_addr == PCPM_OFS_PM_CAP) begin
      dsi_d    = i_pre_wdata[PCPM_POS_DSI];
      aux_d    = i_pre_wdata[PCPM_POS_AUX +: 3];
      d1_d     = i_pre_wdata[PCPM_POS_D1];
      d2_d     = i_pre_wdata[PCPM_POS_D2];
      pmesup_d = i_pre_wdata[PCPM_POS_PMESUP +: 5];
    end else if (i_pre_wr && i_pre_addr == PCPM_OFS_PM_CTRL) begin
      nsr_d    = i_pre_wdata[PCPM_POS_NSR];
      data_d   = i_pre_wdata[PCPM_POS_DATA +: 8];
    end
  end

  // register stage, documented defaults at reset
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dsi_q    <= PCPM_RST_DSI;
      aux_q    <= PCPM_RST_AUX;
      d1_q     <= PCPM_RST_D1;
      d2_q     <= PCPM_RST_D2;
      pmesup_q <= PCPM_RST_PMESUP;
      nsr_q    <= PCPM_RST_NSR;
      data_q   <= PCPM_RST_DATA;
    end else begin
      dsi_q    <= dsi_d;
      aux_q    <= aux_d;
      d1_q     <= d1_d;
      d2_q     <= d2_d;
      pmesup_q <= pmesup_d;
      nsr_q    <= nsr_d;
      data_q   <= data_d;
    end
  end

  assign cap.dsi    = dsi_q;
  assign cap.aux    = aux_q;
  assign cap.d1     = d1_q;
  assign cap.d2     = d2_q;
  assign cap.pmesup = pmesup_q;
  assign cap.nsr    = nsr_q;
  assign cap.data   = data_q;

endmodule

// [rtl/pcpm_hot_reset.sv]
// sequences the internal hot reset after a d3hot to d0 write
`timescale 1ns/1ns
module pcpm_hot_reset
  import pcpm_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_trigger,  // one-cycle: d3hot to d0 with soft reset
  output logic      o_hot_reset // internal reset, registered
);

  // ************************************************************
  // pulse sequencer
  // ************************************************************
  localparam logic [3:0] HR_LAST = 4'(PCPM_HOT_RESET_CYC - 1);

  pcpm_hr_state_t state_q, state_d; // sequencer state
  logic [3:0]     cnt_q, cnt_d;     // cycles left in pulse
  logic           hr_q, hr_d;       // registered output

  // pulse for a fixed count; a retrigger during a pulse restarts it
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    hr_d    = 1'b0;
    case (state_q)
      PCPM_HR_IDLE: begin
        if (i_trigger) begin
          state_d = PCPM_HR_PULSE;
          cnt_d   = HR_LAST;
          hr_d    = 1'b1;
        end
      end
      PCPM_HR_PULSE: begin
        if (i_trigger) begin
          cnt_d = HR_LAST;
          hr_d  = 1'b1;
        end else if (cnt_q == 4'h0) begin
          state_d = PCPM_HR_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
          hr_d  = 1'b1;
        end
      end
      default: begin
        state_d = PCPM_HR_IDLE;
      end
    endcase
  end

  // register stage
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= PCPM_HR_IDLE;
      cnt_q   <= 4'h0;
      hr_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      hr_q    <= hr_d;
    end
  end

  assign o_hot_reset = hr_q;

endmodule

// [rtl/pcpm_cfg_top.sv]
// power-management and msi capability registers of one bridge port
//
// Contract
// - pm capability id reads 01h, writes ignored
// - upstream next pointer reads 9Ch
// - downstream next pointer reads 8Ch
// - pm revision field reads 011b
// - pme clock, b2/b3, bus power bits zero
// - device-specific-init zero, preloadable
// - aux current resets 111b, preloadable
// - d1 and d2 support one, preloadable
// - pme support all ones, preloadable
// - defaults load from loader, not config writes
// - power state writable, resets to d0
// - d3hot to d0 write gives hot reset
// - no-soft-reset set skips internal reset
// - pme enable sticky rw, gates pme messages
// - pme status always reads zero
// - data byte read-only, preloadable, resets zero
// - downstream 8Ch low byte reads 05h
// - downstream port reset output stays deasserted
`timescale 1ns/1ns
module pcpm_cfg_top
  import pcpm_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_port_is_downstream, // strap: 1 downstream port
  input  wire logic        i_cfg_wr,             // config write strobe
  input  wire logic        i_cfg_rd,             // config read strobe
  input  wire logic [7:0]  i_cfg_addr,           // dword byte address
  input  wire logic [3:0]  i_cfg_be,             // byte enables
  input  wire logic [31:0] i_cfg_wdata,          // write data
  input  wire logic        i_pre_wr,             // loader write strobe
  input  wire logic [7:0]  i_pre_addr,           // loader dword address
  input  wire logic [31:0] i_pre_wdata,          // loader data
  input  wire logic        i_pme_event,          // wake event request
  output logic [31:0]      o_cfg_rdata,          // read data
  output logic             o_cfg_rvalid,         // read data valid
  output logic [1:0]       o_power_state,        // current power state
  output logic             o_pme_enable,         // pme enable bit
  output logic             o_pme_msg,            // pme message request
  output logic             o_hot_reset,          // internal hot reset
  output logic             o_downstream_port_reset_out_n // port reset
);

  // ************************************************************
  // helpers
  // ************************************************************

  // write strobe qualified by address and one byte lane
  // reads ignore lanes
  function automatic logic lane_wr(input logic       wr,
                                   input logic [7:0] addr,
                                   input logic [7:0] ofs,
                                   input logic [3:0] be,
                                   input int         lane);
    lane_wr = wr && (addr == ofs) && be[lane];
  endfunction

  // ************************************************************
  // preload store and strap
  // ************************************************************
  // bundle of defaults
  pcpm_cap_if cap (); // preloadable defaults

  // loader writes only; config writes never reach it
  pcpm_preload u_preload (
    .i_clock     (i_clock),
    .i_rst_n     (i_rst_n),
    .i_pre_wr    (i_pre_wr),
    .i_pre_addr  (i_pre_addr),
    .i_pre_wdata (i_pre_wdata),
    .cap         (cap)
  );

  // one role per reset
  logic dn_q, dn_d;       // captured port role
  logic strap_q, strap_d; // role has been captured

  // strap is caught on the first edge after reset release, then frozen
  // later changes ignored
  always_comb begin
    dn_d    = dn_q;
    strap_d = 1'b1;
    if (!strap_q) begin
      dn_d = i_port_is_downstream;
    end
  end

  // strap register stage
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dn_q    <= 1'b0;
      strap_q <= 1'b0;
    end else begin
      dn_q    <= dn_d;
      strap_q <= strap_d;
    end
  end

  // ************************************************************
  // writable control fields
  // ************************************************************
  pcpm_pstate_t pstate_q, pstate_d; // current power state
  logic [3:0]   dsel_q, dsel_d;     // data select
  logic         pmeen_q, pmeen_d;   // pme enable, sticky
  logic         trig_d;             // d3hot to d0 with soft reset
  logic         wr_b0, wr_b1;       // lane writes to 84h
  logic         hr_int;             // internal hot reset from sequencer

  // byte 0: power state
  assign wr_b0 = lane_wr(i_cfg_wr, i_cfg_addr, PCPM_OFS_PM_CTRL, i_cfg_be, 0);

  // byte 1: enable, select
  assign wr_b1 = lane_wr(i_cfg_wr, i_cfg_addr, PCPM_OFS_PM_CTRL, i_cfg_be, 1);

  // next values of the control fields
  always_comb begin
    pstate_d = pstate_q;
    dsel_d   = dsel_q;
    pmeen_d  = pmeen_q;
    trig_d   = 1'b0;

    // hot reset returns non-sticky fields to reset values
    if (hr_int) begin
      pstate_d = PCPM_D0;
      dsel_d   = PCPM_RST_DSEL;
    end

    // a write wins
    if (wr_b0) begin
      pstate_d = pcpm_pstate_t'(i_cfg_wdata[PCPM_POS_PSTATE +: 2]);
      // leaving d3hot for d0 resets only when soft reset is allowed
      if (pstate_q == PCPM_D3HOT &&
          i_cfg_wdata[PCPM_POS_PSTATE +: 2] == PCPM_D0 &&
          !cap.nsr) begin
        trig_d = 1'b1;
      end
    end

    // byte 1 fields
    if (wr_b1) begin
      pmeen_d = i_cfg_wdata[PCPM_POS_PMEEN];
      dsel_d  = i_cfg_wdata[PCPM_POS_DSEL +: 4];
    end
  end

  // control register stage; pme enable survives hot reset
  // only port reset clears it
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pstate_q <= PCPM_D0;
      dsel_q   <= PCPM_RST_DSEL;
      pmeen_q  <= PCPM_RST_PMEEN;
    end else begin
      pstate_q <= pstate_d;
      dsel_q   <= dsel_d;
      pmeen_q  <= pmeen_d;
    end
  end

  // ************************************************************
  // hot reset sequencer
  // ************************************************************
  logic trig_q; // registered trigger

  // registered trigger keeps the sequencer off the write path
  // costs one cycle
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_d;
    end
  end

  // pulse length fixed
  pcpm_hot_reset u_hot_reset (
    .i_clock     (i_clock),
    .i_rst_n     (i_rst_n),
    .i_trigger   (trig_q),
    .o_hot_reset (hr_int)
  );

  // ************************************************************
  // pme message request
  // ************************************************************
  logic pme_q, pme_d; // message request, registered event and enable, high while both hold

  // a message goes out only while software has enabled it
  // status never held
  always_comb begin
    pme_d = i_pme_event && pmeen_q;
  end

  // pme register stage
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pme_q <= 1'b0;
    end else begin
      pme_q <= pme_d;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  logic [31:0] rdata_q, rdata_d; // registered read data
  logic        rvalid_q, rvalid_d;
  logic [7:0]  next_ptr;         // role dependent next pointer

  // next pointer follows the captured role
  // not the live strap
  assign next_ptr = dn_q ? PCPM_NEXT_DN : PCPM_NEXT_UP;

  // read mux; anything unmapped or reserved reads zero
  always_comb begin
    rdata_d  = 32'h0000_0000;
    rvalid_d = i_cfg_rd;

    if (i_cfg_rd) begin
      case (i_cfg_addr)
        PCPM_OFS_PM_CAP: begin
          // capability word
          rdata_d[7:0]                      = PCPM_PM_CAP_ID;
          rdata_d[PCPM_POS_NEXT +: 8]       = next_ptr;
          rdata_d[PCPM_POS_REV +: 3]        = PCPM_PM_REVISION;
          // bit 19 pme clock and bit 20 stay zero
          rdata_d[PCPM_POS_DSI]             = cap.dsi;
          rdata_d[PCPM_POS_AUX +: 3]        = cap.aux;
          rdata_d[PCPM_POS_D1]              = cap.d1;
          rdata_d[PCPM_POS_D2]              = cap.d2;
          rdata_d[PCPM_POS_PMESUP +: 5]     = cap.pmesup;
        end
        PCPM_OFS_PM_CTRL: begin
          // control word
          rdata_d[PCPM_POS_PSTATE +: 2]     = pstate_q;
          rdata_d[PCPM_POS_NSR]             = cap.nsr;
          rdata_d[PCPM_POS_PMEEN]           = pmeen_q;
          rdata_d[PCPM_POS_DSEL +: 4]       = dsel_q;
          // data scale, pme status and bridge bits read zero
          rdata_d[PCPM_POS_DATA +: 8]       = cap.data;
        end
        PCPM_OFS_MSI_CAP: begin
          // upstream has no msi capability here
          if (dn_q) begin
            rdata_d[7:0] = PCPM_MSI_CAP_ID;
          end
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // read register stage; data holds until the next read
  // late readers see it
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rvalid_d;
      if (i_cfg_rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // ************************************************************
  // port reset output
  // ************************************************************
  // tied high, still a flop
  logic dnrst_q; // never asserted by this block

  // a power-state hot reset must not reach the attached device
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dnrst_q <= 1'b1;
    end else begin
      dnrst_q <= 1'b1;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // all outputs from flops
  assign o_cfg_rdata                   = rdata_q;
  assign o_cfg_rvalid                  = rvalid_q;
  assign o_power_state                 = pstate_q;
  assign o_pme_enable                  = pmeen_q;
  assign o_pme_msg                     = pme_q;
  assign o_hot_reset                   = hr_int;
  assign o_downstream_port_reset_out_n = dnrst_q;

endmodule

// [testbench/pcpm_cfg_props.sv]
// assertions on the ports of the pm capability register bank
`timescale 1ns/1ns
module pcpm_cfg_props
  import pcpm_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  input wire logic        i_port_is_downstream,
  input wire logic        i_cfg_wr,
  input wire logic        i_cfg_rd,
  input wire logic [7:0]  i_cfg_addr,
  input wire logic [3:0]  i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic        i_pre_wr,
  input wire logic [7:0]  i_pre_addr,
  input wire logic [31:0] i_pre_wdata,
  input wire logic        i_pme_event,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic        o_cfg_rvalid,
  input wire logic [1:0]  o_power_state,
  input wire logic        o_pme_enable,
  input wire logic        o_pme_msg,
  input wire logic        o_hot_reset,
  input wire logic        o_downstream_port_reset_out_n
);
  // ************************************************************
  // single core clock domain, port reset disables all
  // ************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  // ************************************************************
  // read path and fixed fields
  // ************************************************************
  a_rvalid_cause: assert property (
    o_cfg_rvalid == $past(i_cfg_rd)) else $error("read answer out of step");
  a_pm_id_word: assert property (
    i_cfg_rd && i_cfg_addr == 8'h80 |=> o_cfg_rdata[7:0] == 8'h01
    && o_cfg_rdata[20:16] == 5'h03) else $error("pm id or revision wrong");
  a_next_ptr: assert property (
    i_cfg_rd && i_cfg_addr == 8'h80 |=>
    o_cfg_rdata[15:8] == (i_port_is_downstream ? 8'h8C : 8'h9C)) else $error("next ptr");
  a_ctrl_zeros: assert property (
    i_cfg_rd && i_cfg_addr == 8'h84 |=> o_cfg_rdata[2] == 1'h0
    && o_cfg_rdata[7:4] == 4'h0 && o_cfg_rdata[23:13] == 11'h000) else $error("ctrl zeros");

  // ************************************************************
  // writable fields, events and reset outputs
  // ************************************************************
  a_pstate_write: assert property (
    i_cfg_wr && i_cfg_addr == 8'h84 && i_cfg_be[0] && !o_hot_reset && !$past(i_cfg_wr)
    |=> o_power_state == $past(i_cfg_wdata[1:0])) else $error("power state write lost");
  a_pme_en_write: assert property (
    i_cfg_wr && i_cfg_addr == 8'h84 && i_cfg_be[1]
    |=> o_pme_enable == $past(i_cfg_wdata[8])) else $error("pme enable write lost");
  a_pme_gate: assert property (
    o_pme_msg == $past(i_pme_event && o_pme_enable)) else $error("pme message gating");
  a_port_rst_idle: assert property (
    o_downstream_port_reset_out_n) else $error("port reset driven");
  a_hot_len: assert property (
    $rose(o_hot_reset) |-> o_hot_reset [*4] ##1 !o_hot_reset) else $error("hot reset length");
  a_hot_cause: assert property (
    $rose(o_hot_reset) |-> $past(o_power_state, 2) == 2'h3 && $past(o_power_state) == 2'h0)
    else $error("hot reset without d3hot to d0");
  a_hot_d0: assert property (
    o_hot_reset |-> o_power_state == 2'h0) else $error("state not d0 in hot reset");
endmodule

bind pcpm_cfg_top pcpm_cfg_props u_props (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_port_is_downstream(i_port_is_downstream),
  .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be),
  .i_cfg_wdata(i_cfg_wdata), .i_pre_wr(i_pre_wr), .i_pre_addr(i_pre_addr),
  .i_pre_wdata(i_pre_wdata), .i_pme_event(i_pme_event), .o_cfg_rdata(o_cfg_rdata),
  .o_cfg_rvalid(o_cfg_rvalid), .o_power_state(o_power_state), .o_pme_enable(o_pme_enable),
  .o_pme_msg(o_pme_msg), .o_hot_reset(o_hot_reset),
  .o_downstream_port_reset_out_n(o_downstream_port_reset_out_n));

// [testbench/test_pcie_power_mgmt_capability.sv]
// self-checking bench for the pm capability register bank
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
  $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module test_pcie_power_mgmt_capability
  import pcpm_pkg::*;
;
  // ************************************************************
  // stimulus, observation and bookkeeping
  // ************************************************************
  logic        i_clock = 1'h0;
  logic        i_rst_n = 1'h0;
  logic        i_port_is_downstream = 1'h0;
  logic        i_cfg_wr = 1'h0;
  logic        i_cfg_rd = 1'h0;
  logic [7:0]  i_cfg_addr = 8'h00;
  logic [3:0]  i_cfg_be = 4'h0;
  logic [31:0] i_cfg_wdata = 32'h0;
  logic        i_pre_wr = 1'h0;
  logic [7:0]  i_pre_addr = 8'h00;
  logic [31:0] i_pre_wdata = 32'h0;
  logic        i_pme_event = 1'h0;
  logic [31:0] o_cfg_rdata;
  logic        o_cfg_rvalid;
  logic [1:0]  o_power_state;
  logic        o_pme_enable;
  logic        o_pme_msg;
  logic        o_hot_reset;
  logic        o_downstream_port_reset_out_n;
  int          n_fail = 0;
  int          checks_done = 0;
  int          hot_cnt;
  // top eleven bits of 80h: reset defaults and a loader pattern
  localparam logic [10:0] HI_RST = {PCPM_RST_PMESUP, PCPM_RST_D2, PCPM_RST_D1,
                                    PCPM_RST_AUX, PCPM_RST_DSI};
  localparam logic [10:0] HI_LD  = {5'h0A, 1'h0, 1'h1, 3'h3, 1'h1};

  pcpm_cfg_top dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_port_is_downstream(i_port_is_downstream),
    .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be),
    .i_cfg_wdata(i_cfg_wdata), .i_pre_wr(i_pre_wr), .i_pre_addr(i_pre_addr),
    .i_pre_wdata(i_pre_wdata), .i_pme_event(i_pme_event), .o_cfg_rdata(o_cfg_rdata),
    .o_cfg_rvalid(o_cfg_rvalid), .o_power_state(o_power_state), .o_pme_enable(o_pme_enable),
    .o_pme_msg(o_pme_msg), .o_hot_reset(o_hot_reset),
    .o_downstream_port_reset_out_n(o_downstream_port_reset_out_n));

  // 4 ns core clock
  always #2 i_clock = ~i_clock;

  // ************************************************************
  // expected words and access tasks, all driven at falling edges
  // ************************************************************
  function automatic logic [31:0] cap80(input logic [7:0] nxt, input logic [10:0] hi);
    return {hi, 2'h0, PCPM_PM_REVISION, nxt, PCPM_PM_CAP_ID};
  endfunction

  function automatic logic [31:0] ctl84(input logic [7:0] d, input logic [3:0] sel,
                                        input logic en, input logic nsr, input logic [1:0] ps);
    return {d, 8'h00, 3'h0, sel, en, 4'h0, nsr, 1'h0, ps};
  endfunction

  // strap held from reset on, since it is captured once after release
  task automatic do_reset(input logic dn);
    i_rst_n = 1'h0;
    i_port_is_downstream = dn;
    repeat (2) @(negedge i_clock);
    i_rst_n = 1'h1;
    repeat (2) @(negedge i_clock);
  endtask

  // read one dword and compare the masked bits
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    int n;
    n = 0;
    i_cfg_rd = 1'h1;
    i_cfg_addr = a;
    @(negedge i_clock);
    i_cfg_rd = 1'h0;
    while (o_cfg_rvalid !== 1'h1 && n < 4) begin
      @(negedge i_clock);
      n++;
    end
    `CHK(o_cfg_rvalid, 1'h1)
    `CHK(o_cfg_rdata & m, e & m)
    @(negedge i_clock);
  endtask

  // extra falling edge so a following strobe is never re-raised at once
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    i_cfg_wr = 1'h1;
    i_cfg_addr = a;
    i_cfg_be = b;
    i_cfg_wdata = d;
    @(negedge i_clock);
    i_cfg_wr = 1'h0;
    @(negedge i_clock);
  endtask

  task automatic pre_write(input logic [7:0] a, input logic [31:0] d);
    i_pre_wr = 1'h1;
    i_pre_addr = a;
    i_pre_wdata = d;
    @(negedge i_clock);
    i_pre_wr = 1'h0;
    @(negedge i_clock);
  endtask

  // count hot reset cycles over a window longer than the pulse
  task automatic count_hot();
    hot_cnt = 0;
    repeat (8) begin
      if (o_hot_reset === 1'h1) hot_cnt++;
      @(negedge i_clock);
    end
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    do_reset(1'h0);
    rd_chk(8'h80, cap80(PCPM_NEXT_UP, HI_RST), '1);
    rd_chk(8'h84, ctl84(8'h00, 4'h0, 1'h0, 1'h1, 2'h0), '1);
    rd_chk(8'h8C, 32'h0, '1);
    rd_chk(8'h40, 32'h0, '1);
    // config writes must not touch the read-only capability word
    cfg_write(8'h80, 4'hF, 32'hFFFF_FFFF);
    rd_chk(8'h80, cap80(PCPM_NEXT_UP, HI_RST), '1);
    for (int i = 0; i < 4; i++) begin
      cfg_write(8'h84, 4'h1, i);
      `CHK(o_power_state, i[1:0])
    end
    cfg_write(8'h84, 4'hF, 32'hFFFF_FFFF);
    rd_chk(8'h84, ctl84(8'h00, 4'hF, 1'h1, 1'h1, 2'h3), '1);
    // wake events pass only while enabled
    i_pme_event = 1'h1;
    @(negedge i_clock);
    `CHK(o_pme_msg, 1'h1)
    cfg_write(8'h84, 4'h2, 32'h0);
    @(negedge i_clock);
    `CHK(o_pme_msg, 1'h0)
    i_pme_event = 1'h0;
    cfg_write(8'h84, 4'h2, 32'h1F00);
    // d3hot to d0 with no-soft-reset set: no internal reset
    cfg_write(8'h84, 4'h1, 32'h0);
    count_hot();
    `CHK(hot_cnt, 0)
    // loader overrides the preloadable defaults
    pre_write(8'h84, {8'hA5, 20'h0, 4'h7});
    pre_write(8'h80, {HI_LD, 21'h1FFFFF});
    rd_chk(8'h84, ctl84(8'hA5, 4'hF, 1'h1, 1'h0, 2'h0), '1);
    rd_chk(8'h80, cap80(PCPM_NEXT_UP, HI_LD), '1);
    // no-soft-reset now clear: d3hot to d0 gives the hot reset
    cfg_write(8'h84, 4'h1, 32'h3);
    cfg_write(8'h84, 4'h1, 32'h0);
    count_hot();
    `CHK(hot_cnt, 4)
    `CHK(o_downstream_port_reset_out_n, 1'h1)
    rd_chk(8'h84, ctl84(8'hA5, 4'h0, 1'h1, 1'h0, 2'h0), '1);
    // mid-run reset as a downstream port restores the defaults
    do_reset(1'h1);
    `CHK(o_pme_enable, 1'h0)
    rd_chk(8'h80, cap80(PCPM_NEXT_DN, HI_RST), '1);
    rd_chk(8'h8C, {24'h0, PCPM_MSI_CAP_ID}, 32'hFF);
    rd_chk(8'h84, ctl84(8'h00, 4'h0, 1'h0, 1'h1, 2'h0), '1);
    give_verdict();
  end

  // the sequence takes some 76 cycles; about twenty times that marks a hang
  initial begin
    #6000;
    n_fail++;
    give_verdict();
  end
endmodule
